// ===== pwm_port_pkg.sv
`default_nettype none

package pwm_port_pkg;

  // ***************************************
  // register indices, byte address is four times the index
  // ***************************************
  localparam logic [7:0] IDX_ENABLE_POL = 8'h40;
  localparam logic [7:0] IDX_SCALE0     = 8'h44;
  localparam logic [7:0] IDX_SCALE_CNT0 = 8'h45;
  localparam logic [7:0] IDX_SCALE1     = 8'h46;
  localparam logic [7:0] IDX_SCALE_CNT1 = 8'h47;
  localparam logic [7:0] IDX_COUNTER0   = 8'h48;
  localparam logic [7:0] IDX_PERIOD0    = 8'h4c;
  localparam logic [7:0] IDX_DUTY0      = 8'h50;
  localparam logic [7:0] IDX_CONTROL    = 8'h54;
  localparam logic [7:0] IDX_SPECIAL    = 8'h55;
  localparam logic [7:0] IDX_PORT_DATA  = 8'h56;
  localparam logic [7:0] IDX_PORT_DIR   = 8'h57;

  // ***************************************
  // field positions
  // ***************************************
  localparam int CTL_HALT_DEBUG   = 0;
  localparam int CTL_PULLUP       = 1;
  localparam int CTL_REDUCED      = 2;
  localparam int CTL_CENTER       = 3;
  localparam int TST_NO_CNT_CLEAR = 2;  // bit 7 of the test register
  localparam int TST_NO_RESTART   = 1;  // bit 6
  localparam int TST_NO_RELOAD    = 0;  // bit 5
  localparam int TST_LSB          = 5;
  localparam int NUM_CHANNELS     = 4;

  // ***************************************
  // values after reset, and the full duty value
  // ***************************************
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_DUTY   = 8'hff;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] DUTY_FULL  = 8'hff;

endpackage

`default_nettype wire

// ===== pwm_chan_if.sv
`default_nettype none

// one channel's controls and results between port control and channel
interface pwm_chan_if;
  logic       ce;
  logic       tick;
  logic       en;
  logic       center;
  logic       pol;
  logic       no_restart;
  logic       cnt_wr;
  logic       cnt_clr;
  logic [7:0] per_val;
  logic [7:0] dty_val;
  logic [7:0] cnt;
  logic       pwm;
  modport ctrl (output ce, tick, en, center, pol, no_restart, cnt_wr, cnt_clr,
                output per_val, dty_val, input cnt, pwm);
  modport chan (input ce, tick, en, center, pol, no_restart, cnt_wr, cnt_clr,
                input per_val, dty_val, output cnt, pwm);
endinterface

`default_nettype wire

// ===== pwm_channel.sv
`default_nettype none

module pwm_channel
  import pwm_port_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control side
  pwm_chan_if.chan  cif
);

  import pwm_port_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] per_a;
    logic [7:0] dty_a;
    logic       down;
    logic       pwm;
  } chan_state_type;

  chan_state_type s_q;
  chan_state_type s_d;

  // ***************************************
  // counting and output level
  // ***************************************
  always_comb
  begin
    s_d = s_q;
    if (cif.cnt_wr)
    begin
      if (cif.cnt_clr)
      begin
        s_d.cnt   = RST_ZERO;
        s_d.down  = 1'b0;
        s_d.per_a = cif.per_val;
        s_d.dty_a = cif.dty_val;
      end
    end
    else if (!cif.en)
    begin
      // a disabled channel takes new values at once
      s_d.per_a = cif.per_val;
      s_d.dty_a = cif.dty_val;
    end
    else if (cif.tick)
    begin
      if (!cif.center)
      begin
        if (s_q.cnt == s_q.per_a && !cif.no_restart)
        begin
          s_d.cnt   = RST_ZERO;
          s_d.per_a = cif.per_val;
          s_d.dty_a = cif.dty_val;
        end
        else
          s_d.cnt = s_q.cnt + 8'h01;
      end
      else if (s_q.per_a == RST_ZERO)
        s_d.cnt = RST_ZERO;
      else if (!s_q.down)
      begin
        // turn at the period match
        if (s_q.cnt >= s_q.per_a)
        begin
          s_d.down = 1'b1;
          s_d.cnt  = s_q.cnt - 8'h01;
        end
        else
          s_d.cnt = s_q.cnt + 8'h01;
      end
      else if (s_q.cnt == RST_ZERO)
      begin
        s_d.down  = 1'b0;
        s_d.cnt   = 8'h01;
        s_d.per_a = cif.per_val;
        s_d.dty_a = cif.dty_val;
      end
      else
        s_d.cnt = s_q.cnt - 8'h01;
    end
    // boundary cases first, then the normal compare
    if (s_q.per_a == RST_ZERO)
      s_d.pwm = cif.pol;
    else if (!cif.center && s_q.dty_a == DUTY_FULL)
      s_d.pwm = !cif.pol;
    else if (cif.center && s_q.dty_a == RST_ZERO)
      s_d.pwm = !cif.pol;
    else if (s_q.dty_a >= s_q.per_a)
      s_d.pwm = cif.pol;
    else if (!cif.center)
      s_d.pwm = (s_q.cnt <= s_q.dty_a) ? cif.pol : !cif.pol;
    else
      // match going up ends the pulse, match going down starts it: duty over period
      s_d.pwm = (s_q.down ? s_q.cnt <= s_q.dty_a : s_q.cnt < s_q.dty_a) ? cif.pol : !cif.pol;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '{cnt: RST_ZERO, per_a: RST_PERIOD, dty_a: RST_DUTY, down: 1'b0, pwm: 1'b0};
    else if (cif.ce)
      s_q <= s_d;
  end

  assign cif.cnt = s_q.cnt;
  assign cif.pwm = s_q.pwm;

  // ***************************************
  // checks
  // ***************************************
  a_cnt_write_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cif.ce && cif.cnt_wr && cif.cnt_clr |=> s_q.cnt == RST_ZERO)
    else $error("counter write did not clear");
  a_cnt_write_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cif.ce && cif.cnt_wr && !cif.cnt_clr |=> s_q.cnt == $past(s_q.cnt))
    else $error("inhibited counter write changed counter");
  a_zero_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cif.ce && s_q.per_a == RST_ZERO |=> s_q.pwm == $past(cif.pol))
    else $error("zero period output not at polarity");
  a_center_turn: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cif.ce && cif.en && cif.tick && cif.center && !cif.cnt_wr && !s_q.down
    && s_q.per_a != RST_ZERO && s_q.cnt == s_q.per_a |=> s_q.down)
    else $error("center counter did not turn at period");
  c_center_turn: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(s_q.down));

endmodule

`default_nettype wire

// ===== pwm_port_ctrl.sv
// The implementer's own choice: register access over Wishbone.
`default_nettype none

module pwm_port_ctrl
  import pwm_port_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic [9:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // device mode
  input  wire logic        special_mode_n_i,
  input  wire logic        debug_mode_i,
  // port pins
  input  wire logic [7:0]  port_pin_i,
  output logic      [7:0]  port_out_o,
  output logic      [7:0]  port_oe_n_o,
  output logic             port_pullup_en_o,
  output logic             port_reduced_drive_o
);

  import pwm_port_pkg::*;

  typedef struct packed {
    logic            ack;
    logic [7:0]      rdat;
    logic [2:0]      test;
    logic [3:0]      ctl;
    logic [3:0]      en;
    logic [3:0]      pol;
    logic [7:0]      scal0;
    logic [7:0]      scal1;
    logic [7:0]      scnt0;
    logic [7:0]      scnt1;
    logic [3:0][7:0] per;
    logic [3:0][7:0] dty;
    logic [7:0]      dat;
    logic [7:0]      dir;
    logic [3:0]      cwr;
    logic [3:0]      tick;
    logic [7:0]      pout;
    logic [7:0]      poe_n;
    logic [7:0]      pin_s1;
    logic [7:0]      pin_s2;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;

  logic       acc;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       run;
  logic       load0;
  logic       load1;
  logic [3:0] ch_pwm;
  logic [3:0][7:0] ch_cnt;
  logic [7:0] en8;
  logic [7:0] pin_rd;

  pwm_chan_if ch_if [NUM_CHANNELS] ();

  // ***************************************
  // bus decode
  // ***************************************
  // one request per ack; ack drops in the cycle after it was given
  assign acc   = cyc_i && stb_i && !s_q.ack;
  assign wr    = acc && we_i && sel_i[0];
  assign idx   = adr_i[9:2];
  assign wbyte = dat_i[7:0];
  // channel clock stops in debug when asked to
  assign run   = !(s_q.ctl[CTL_HALT_DEBUG] && debug_mode_i);
  assign load0 = wr && idx == IDX_SCALE0 && !s_q.test[TST_NO_RELOAD];
  assign load1 = wr && idx == IDX_SCALE1 && !s_q.test[TST_NO_RELOAD];
  assign en8   = {4'h0, s_q.en};
  // inputs show the pin, outputs the latch
  assign pin_rd = (s_q.dir & s_q.dat) | (~s_q.dir & s_q.pin_s2);

  // ***************************************
  // next state
  // ***************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.ack    = acc;
    s_d.cwr    = 4'h0;
    s_d.pin_s1 = port_pin_i;
    s_d.pin_s2 = s_q.pin_s1;

    // scale down-counters, reload on reaching zero
    s_d.tick = 4'h0;
    if (run)
    begin
      if (s_q.scnt0 == RST_ZERO)
      begin
        s_d.scnt0 = s_q.scal0;
        s_d.tick[1:0] = 2'b11;
      end
      else
        s_d.scnt0 = s_q.scnt0 - 8'h01;
      if (s_q.scnt1 == RST_ZERO)
      begin
        s_d.scnt1 = s_q.scal1;
        s_d.tick[3:2] = 2'b11;
      end
      else
        s_d.scnt1 = s_q.scnt1 - 8'h01;
    end

    // register writes
    if (wr)
    begin
      case (idx)
        IDX_ENABLE_POL:
        begin
          s_d.en  = wbyte[3:0];
          s_d.pol = wbyte[7:4];
        end
        IDX_SCALE0:
        begin
          s_d.scal0 = wbyte;
          if (load0)
            s_d.scnt0 = wbyte;
        end
        IDX_SCALE1:
        begin
          s_d.scal1 = wbyte;
          if (load1)
            s_d.scnt1 = wbyte;
        end
        IDX_CONTROL:    s_d.ctl = wbyte[3:0];
        IDX_SPECIAL:
        begin
          // low five bits are not stored
          if (!special_mode_n_i)
            s_d.test = wbyte[7:TST_LSB];
        end
        IDX_PORT_DATA:  s_d.dat = wbyte;
        IDX_PORT_DIR:   s_d.dir = wbyte;
        default:
        begin
          // channel counters, periods and duties sit in blocks of four
          if (idx[7:2] == IDX_COUNTER0[7:2])
            s_d.cwr[idx[1:0]] = 1'b1;
          else if (idx[7:2] == IDX_PERIOD0[7:2])
            s_d.per[idx[1:0]] = wbyte;
          else if (idx[7:2] == IDX_DUTY0[7:2])
            s_d.dty[idx[1:0]] = wbyte;
        end
      endcase
    end

    // test bits exist only in special mode
    if (special_mode_n_i)
      s_d.test = 3'h0;

    // read data, unmapped reads answer zero
    if (acc)
    begin
      case (idx)
        IDX_ENABLE_POL: s_d.rdat = {s_q.pol, s_q.en};
        IDX_SCALE0:     s_d.rdat = s_q.scal0;
        IDX_SCALE_CNT0: s_d.rdat = s_q.scnt0;
        IDX_SCALE1:     s_d.rdat = s_q.scal1;
        IDX_SCALE_CNT1: s_d.rdat = s_q.scnt1;
        IDX_CONTROL:    s_d.rdat = {4'h0, s_q.ctl};
        IDX_SPECIAL:    s_d.rdat = {s_q.test, 5'h00};
        IDX_PORT_DATA:  s_d.rdat = pin_rd;
        IDX_PORT_DIR:   s_d.rdat = s_q.dir;
        default:
        begin
          if (idx[7:2] == IDX_COUNTER0[7:2])
            s_d.rdat = ch_cnt[idx[1:0]];
          else if (idx[7:2] == IDX_PERIOD0[7:2])
            s_d.rdat = s_q.per[idx[1:0]];
          else if (idx[7:2] == IDX_DUTY0[7:2])
            s_d.rdat = s_q.dty[idx[1:0]];
          else
            s_d.rdat = RST_ZERO;
        end
      endcase
    end

    // pin drive: enabled channels take pins 3..0 over the port latch
    s_d.pout  = (en8 & {4'h0, ch_pwm}) | (~en8 & s_q.dat);
    s_d.poe_n = ~(en8 | s_q.dir);
  end

  // ***************************************
  // state register
  // ***************************************
  // pins come up as inputs with no drive
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '{ack: 1'b0, rdat: RST_ZERO, test: 3'h0, ctl: 4'h0, en: 4'h0, pol: 4'h0,
               scal0: RST_ZERO, scal1: RST_ZERO, scnt0: RST_ZERO, scnt1: RST_ZERO,
               per: {4{RST_PERIOD}}, dty: {4{RST_DUTY}}, dat: RST_ZERO, dir: RST_ZERO,
               cwr: 4'h0, tick: 4'h0, pout: RST_ZERO, poe_n: 8'hff,
               pin_s1: RST_ZERO, pin_s2: RST_ZERO};
    else if (ce_i)
      s_q <= s_d;
  end

  // ***************************************
  // channels
  // ***************************************
  for (genvar g = 0; g < NUM_CHANNELS; g++)
  begin : g_chan
    assign ch_if[g].ce         = ce_i;
    assign ch_if[g].tick       = s_q.tick[g];
    assign ch_if[g].en         = s_q.en[g];
    assign ch_if[g].center     = s_q.ctl[CTL_CENTER];
    assign ch_if[g].pol        = s_q.pol[g];
    assign ch_if[g].no_restart = s_q.test[TST_NO_RESTART];
    assign ch_if[g].cnt_wr     = s_q.cwr[g];
    assign ch_if[g].cnt_clr    = !s_q.test[TST_NO_CNT_CLEAR];
    assign ch_if[g].per_val    = s_q.per[g];
    assign ch_if[g].dty_val    = s_q.dty[g];
    assign ch_pwm[g]           = ch_if[g].pwm;
    assign ch_cnt[g]           = ch_if[g].cnt;
    pwm_channel u_chan (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .cif     (ch_if[g])
    );
  end

  // ***************************************
  // outputs, all from flip-flops
  // ***************************************
  assign dat_o                = {24'h000000, s_q.rdat};
  assign ack_o                = s_q.ack;
  assign port_out_o           = s_q.pout;
  assign port_oe_n_o          = s_q.poe_n;
  assign port_pullup_en_o     = s_q.ctl[CTL_PULLUP];
  assign port_reduced_drive_o = s_q.ctl[CTL_REDUCED];

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_test_normal_zero: assert property (
    ce_i && special_mode_n_i |=> s_q.test == 3'h0)
    else $error("test bits set outside special mode");
  a_halt_no_tick: assert property (
    ce_i && s_q.ctl[CTL_HALT_DEBUG] && debug_mode_i |=> s_q.tick == 4'h0)
    else $error("channel clock ran while halted in debug");
  a_pin_override: assert property (
    ce_i && s_q.en[0] |=> port_out_o[0] == $past(ch_pwm[0]) && !port_oe_n_o[0])
    else $error("enabled channel not on its pin");
  a_port_latch_drive: assert property (
    ce_i && !s_q.en[1] && s_q.dir[1] |=> port_out_o[1] == $past(s_q.dat[1]))
    else $error("port latch not driven on output pin");
  a_dir_input_float: assert property (
    ce_i && !s_q.dir[7] |=> port_oe_n_o[7])
    else $error("input pin is driven");
  a_scale_load: assert property (
    ce_i && load0 |=> s_q.scnt0 == $past(wbyte))
    else $error("scale write did not load counter");
  a_scale_no_load: assert property (
    ce_i && wr && idx == IDX_SCALE0 && s_q.test[TST_NO_RELOAD] && s_q.scnt0 != RST_ZERO
    |=> s_q.scnt0 == $past(s_q.scnt0) - {7'h00, $past(run)})
    else $error("inhibited scale write loaded counter");
  a_read_pin_level: assert property (
    ce_i && acc && !we_i && idx == IDX_PORT_DATA && !s_q.dir[2]
    |=> dat_o[2] == $past(s_q.pin_s2[2]))
    else $error("input read is not the pin level");
  a_drive_follows: assert property (
    ce_i && wr && idx == IDX_CONTROL |=> ##1 port_reduced_drive_o == $past(wbyte[2], 2))
    else $error("reduced drive does not follow control");
  a_ack_one_cycle: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  c_special_write: cover property (wr && idx == IDX_SPECIAL && !special_mode_n_i);
  c_center_run: cover property (s_q.ctl[CTL_CENTER] && s_q.en != 4'h0);
  c_port_drive: cover property (s_q.dir != RST_ZERO && s_q.en == 4'h0);

endmodule

`default_nettype wire

// ===== pwm_pin_load.sv
`default_nettype none

// pin loads seen by the shared port: bench sources, pull-ups, floating lines
module pwm_pin_load
(
  // clock
  input  wire logic       clk_i,
  // device side
  input  wire logic [7:0] port_out_i,
  input  wire logic [7:0] port_oe_n_i,
  input  wire logic       pullup_en_i,
  // bench-driven external sources
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  // resolved pin levels
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] float_q = 8'h5a;

  // undriven lines wander every cycle, so a stale level never passes for a read
  always_ff @(posedge clk_i)
    float_q <= ~float_q;

  // device drive wins, then an external source, then the pull-up
  always_comb
    for (int n = 0; n < 8; n++)
      pin_o[n] = !port_oe_n_i[n] ? port_out_i[n] :
                 ext_en_i[n]     ? ext_val_i[n]  :
                 pullup_en_i     ? 1'b1          : float_q[n];
endmodule

`default_nettype wire

// ===== tb_pwm_mode_test_and_port_control.sv
`default_nettype none

module tb_pwm_mode_test_and_port_control;
  timeunit 1ns;
  timeprecision 100ps;
  import pwm_port_pkg::*;

  logic        clk_i;
  logic        rst_n_i;
  logic [9:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic        we;
  logic        cyc;
  logic        stb;
  logic [31:0] rdat;
  logic        ack;
  logic        smode_n;
  logic        dbg;
  logic [7:0]  pin;
  logic [7:0]  pout;
  logic [7:0]  oe_n;
  logic        pup;
  logic        rdrv;
  logic [7:0]  ext_en;
  logic [7:0]  ext_val;
  logic [7:0]  rv;
  logic [7:0]  v;
  logic [7:0]  dir;
  logic [7:0]  lat;
  logic [7:0]  ext;
  logic [7:0]  ext_exp;
  logic        pu;
  int          hi;
  int          exp_hi;
  int          err_total;
  int          n_checks;
  int          mreg [int];
  // center, duty, period, polarity, high count, window (0 = constant level)
  int          cs [10][6] = '{'{0, 255, 16, 1, 0, 0}, '{0, 255, 16, 0, 1, 0},
                              '{1, 0, 16, 1, 0, 0}, '{1, 0, 16, 0, 1, 0},
                              '{0, 32, 16, 1, 1, 0}, '{1, 32, 16, 0, 0, 0},
                              '{0, 5, 0, 1, 1, 0}, '{1, 5, 0, 0, 0, 0},
                              '{0, 3, 9, 1, 16, 40}, '{1, 3, 8, 1, 24, 64}};

  pwm_port_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat),
    .ack_o(ack), .special_mode_n_i(smode_n), .debug_mode_i(dbg), .port_pin_i(pin),
    .port_out_o(pout), .port_oe_n_o(oe_n), .port_pullup_en_o(pup),
    .port_reduced_drive_o(rdrv));

  pwm_pin_load u_load (.clk_i(clk_i), .port_out_i(pout), .port_oe_n_i(oe_n),
    .pullup_en_i(pup), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin));

  // ***************************************
  // checking and bus helpers
  // ***************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; ack is seen at the edge before the design's own update lands
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h000000, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rv = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
      chk("bus ack", 8'h01, 8'h00);
  endtask

  // write and keep the register mirror in step
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
    if (idx == IDX_SPECIAL)
    begin
      if (smode_n === 1'b0)
        mreg[idx] = wd & 8'he0;
    end
    else if (mreg.exists(idx))
      mreg[idx] = wd;
  endtask

  // read and compare with the mirror; unlisted places read zero
  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), mreg.exists(idx) ? 8'(mreg[idx]) : 8'h00, rv);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ***************************************
  // clock and watchdog
  // ***************************************
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // the whole sequence needs a few thousand cycles; this leaves ample margin
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("MISMATCH watchdog expected done seen timeout");
    end_of_test;
  end

  // ***************************************
  // main sequence
  // ***************************************
  initial
  begin
    rst_n_i = 1'b0;
    adr = 10'h000;
    wdat = 32'h00000000;
    sel = 4'h1;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    smode_n = 1'b1;
    dbg = 1'b0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h9db1));
    mreg[IDX_ENABLE_POL] = 0;
    mreg[IDX_CONTROL] = 0;
    mreg[IDX_SPECIAL] = 0;
    mreg[IDX_PORT_DIR] = 0;
    mreg[IDX_PERIOD0] = 255;
    mreg[IDX_DUTY0] = 255;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk("oe_n reset", 8'hff, oe_n);
    chk("pullup reset", 8'h00, {7'h00, pup});
    chk("reduced reset", 8'h00, {7'h00, rdrv});
    rd(IDX_PORT_DIR);
    rd(IDX_CONTROL);
    rd(IDX_PERIOD0);
    rd(8'h80);

    // port data and direction, random values; later passes float inputs on pull-ups
    for (int i = 0; i < 6; i++)
    begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      ext = 8'($urandom);
      pu = (i > 3) | i[0];
      ext_exp = (i > 3) ? 8'hff : ext;
      ext_val <= ext;
      ext_en <= (i > 3) ? 8'h00 : ~dir;
      wr(IDX_CONTROL, {5'h00, i[1], pu, 1'b0});
      wr(IDX_PORT_DATA, lat);
      wr(IDX_PORT_DIR, dir);
      repeat (4) @(posedge clk_i);
      chk("oe_n", ~dir, oe_n);
      chk("pin out", lat & dir, pout & dir);
      chk("pullup", {7'h00, pu}, {7'h00, pup});
      chk("reduced", {7'h00, i[1]}, {7'h00, rdrv});
      bus(1'b0, IDX_PORT_DATA, 8'h00);
      chk("data read", (lat & dir) | (ext_exp & ~dir), rv);
      rd(IDX_PORT_DIR);
    end

    // test register only takes writes in special mode, unused bits stay zero
    wr(IDX_SPECIAL, 8'hff);
    rd(IDX_SPECIAL);
    smode_n <= 1'b0;
    wr(IDX_SPECIAL, 8'hff);
    rd(IDX_SPECIAL);
    smode_n <= 1'b1;
    mreg[IDX_SPECIAL] = 0;
    repeat (2) @(posedge clk_i);
    rd(IDX_SPECIAL);

    // boundary levels and duty counts on channel 0; pin 0 left as input
    wr(IDX_PORT_DIR, 8'h00);
    foreach (cs[k])
    begin
      wr(IDX_ENABLE_POL, 8'h00);
      wr(IDX_CONTROL, 8'(cs[k][0] << 3));
      rd(IDX_CONTROL);
      wr(IDX_PERIOD0, 8'(cs[k][2]));
      wr(IDX_DUTY0, 8'(cs[k][1]));
      wr(IDX_COUNTER0, 8'h00);
      wr(IDX_ENABLE_POL, {3'h0, cs[k][3][0], 4'h1});
      repeat (100) @(posedge clk_i);
      hi = 0;
      for (int t = 0; t < ((cs[k][5] > 0) ? cs[k][5] : 40); t++)
      begin
        @(posedge clk_i);
        if (pout[0] === 1'b1)
          hi++;
      end
      exp_hi = (cs[k][5] > 0) ? cs[k][4] : cs[k][4] * 40;
      chk("high count", 8'(exp_hi), 8'(hi));
      chk("channel drive", 8'h00, {7'h00, oe_n[0]});
    end
    wr(IDX_ENABLE_POL, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("pin released", 8'h01, {7'h00, oe_n[0]});

    // counter test bits: period restart off, then clear-on-write off
    smode_n <= 1'b0;
    wr(IDX_SPECIAL, 8'h40);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_PERIOD0, 8'h10);
    wr(IDX_COUNTER0, 8'h00);
    wr(IDX_ENABLE_POL, 8'h01);
    repeat (60) @(posedge clk_i);
    wr(IDX_ENABLE_POL, 8'h00);
    bus(1'b0, IDX_COUNTER0, 8'h00);
    v = rv;
    chk("past period", 8'h01, {7'h00, v > 8'h10});
    wr(IDX_SPECIAL, 8'hc0);
    wr(IDX_COUNTER0, 8'h00);
    bus(1'b0, IDX_COUNTER0, 8'h00);
    chk("kept count", v, rv);
    wr(IDX_SPECIAL, 8'h00);
    wr(IDX_COUNTER0, 8'h00);
    bus(1'b0, IDX_COUNTER0, 8'h00);
    chk("cleared count", 8'h00, rv);
    wr(IDX_ENABLE_POL, 8'h01);
    repeat (60) @(posedge clk_i);
    bus(1'b0, IDX_COUNTER0, 8'h00);
    chk("wraps at period", 8'h01, {7'h00, rv <= 8'h10});
    wr(IDX_ENABLE_POL, 8'h00);

    // scale counter load, load inhibit, and halt in debug
    wr(IDX_SCALE0, 8'h80);
    bus(1'b0, IDX_SCALE_CNT0, 8'h00);
    chk("scale loaded", 8'h01, {7'h00, (rv <= 8'h80) && (rv >= 8'h78)});
    wr(IDX_SPECIAL, 8'h20);
    wr(IDX_SCALE0, 8'h10);
    bus(1'b0, IDX_SCALE_CNT0, 8'h00);
    chk("scale kept", 8'h01, {7'h00, rv > 8'h10});
    wr(IDX_SPECIAL, 8'h00);
    wr(IDX_SCALE0, 8'h80);
    wr(IDX_CONTROL, 8'h01);
    dbg <= 1'b1;
    bus(1'b0, IDX_SCALE_CNT0, 8'h00);
    v = rv;
    repeat (20) @(posedge clk_i);
    bus(1'b0, IDX_SCALE_CNT0, 8'h00);
    chk("halted scale", v, rv);
    dbg <= 1'b0;
    bus(1'b0, IDX_SCALE_CNT0, 8'h00);
    chk("running scale", 8'h01, {7'h00, rv != v});
    smode_n <= 1'b1;
    end_of_test;
  end
endmodule

`default_nettype wire
